// >>> crs_pkg.sv
// Package for the core reset state block: coprocessor register numbers,
// field positions, reset values and the carrier types.
// Assumes a 32-bit core and coprocessor accesses by register and select number.
package crs_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int XLEN      = 32;
  localparam int STATIC_W  = 16;

  // ----------------------------------------------------------------------
  // Coprocessor register and select numbers
  // ----------------------------------------------------------------------
  localparam logic [4:0] REG_RANDOM  = 5'h01;
  localparam logic [4:0] REG_CTXCFG  = 5'h04;
  localparam logic [4:0] REG_PGRAIN  = 5'h05;
  localparam logic [4:0] REG_WIRED   = 5'h06;
  localparam logic [4:0] REG_COMPARE = 5'h0b;
  localparam logic [4:0] REG_STATUS  = 5'h0c;
  localparam logic [4:0] REG_CONFIG  = 5'h10;
  localparam logic [4:0] REG_WATCH   = 5'h12;
  localparam logic [4:0] REG_DEBUG   = 5'h17;
  localparam logic [4:0] REG_SCRATCH = 5'h1f;
  localparam logic [2:0] SEL_ZERO    = 3'h0;
  localparam logic [2:0] SEL_ONE     = 3'h1;
  localparam logic [2:0] SEL_CONFIG_WORD_FOUR = 3'h4;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int ST_ERL  = 2;
  localparam int ST_NMI  = 19;
  localparam int ST_SR   = 20;
  localparam int ST_TS   = 21;
  localparam int ST_BEV  = 22;
  localparam int ST_RP   = 27;
  localparam int DB_FETCH_EXEC_INHIBIT = 5;
  localparam int DB_SST  = 8;
  localparam int DB_DBEP = 21;
  localparam int DB_IBEP = 24;
  localparam int DB_LOADSTORE_NORMAL_ACCESS = 28;
  localparam int DB_DM   = 30;
  localparam int CF_K0   = 0;
  localparam int CF_STAT = 3;
  localparam int CF_KU   = 25;
  localparam int CF_K23  = 28;
  localparam int C4_MASK = 16;

  // ----------------------------------------------------------------------
  // Reset values and fixed addresses
  // ----------------------------------------------------------------------
  localparam logic [2:0]      CCA_UNCACHED  = 3'h2;
  localparam logic [XLEN-1:0] CTX_RESET     = 32'h007ffff0;
  localparam logic [1:0]      PG_MASK_RESET = 2'h3;
  localparam logic [XLEN-1:0] BOOT_VA       = 32'hbfc00000;
  localparam logic [XLEN-1:0] BOOT_PA       = 32'h1fc00000;
  localparam logic [XLEN-1:0] SEG_PHYS_MASK = 32'h1fffffff;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    BIU_IDLE = 2'b00,
    BIU_PEND = 2'b01
  } crs_biu_state_t;

  typedef struct packed {
    logic            rd;
    logic            wr;
    logic [4:0]      regn;
    logic [2:0]      sel;
    logic [XLEN-1:0] wdata;
  } crs_cp_req_t;

  typedef struct packed {
    logic boot_vector_select;
    logic ts;
    logic sr;
    logic nmi;
    logic error_level;
    logic rp;
    logic dm;
  } crs_arch_flags_t;

endpackage : crs_pkg

// >>> crs_scratch_word.sv
// One plain read/write storage word with no reset value.
// Assumes the caller gates the write strobe with clock enable and reset.
`timescale 1ns/1ps
module crs_scratch_word
  import crs_pkg::*;
#(
  parameter int W = XLEN
) (
  // Clock
  input  wire logic         clk,
  // Write side
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wdata,
  // Stored value
  output logic [W-1:0]      q
);

  // Elaboration check: a word needs at least one bit
  if (W < 1) begin : g_bad_w
    $error("W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] word;
  } crs_word_state_t;

  crs_word_state_t s_q;
  crs_word_state_t s_d;

  // Hold the last written value
  always_comb begin
    s_d = s_q;
    if (wr_en) begin
      s_d.word = wdata;
    end
  end

  // Storage flops, deliberately without reset
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign q = s_q.word;

endmodule : crs_scratch_word

// >>> crs_core_reset.sv
// Reset initialisation of the core control state (scratch words keep no reset value),
// translation-entry hidden bits, bus abort and first fetch.
// Assumes one clock, synchronous resets and a coprocessor access port.
`timescale 1ns/1ps
module crs_core_reset
  import crs_pkg::*;
#(
  parameter int              TLB_ENTRIES = 16,
  parameter bit              HAS_TLB     = 1'b1,
  parameter bit              FIXED_MAP   = 1'b0,
  parameter bit              DEBUG_IMPL  = 1'b1,
  parameter logic [7:0]      KSCR_MASK   = 8'h0c,
  parameter logic [XLEN-1:0] DEBUG_VA    = 32'hff200200
) (
  // Clock, enable and resets
  input  wire logic                   SYS_CLK,
  input  wire logic                   RST,
  input  wire logic                   SOFT_RST,
  input  wire logic                   CE,
  // Static configuration
  input  wire logic                   DEBUG_BOOT,
  input  wire logic [STATIC_W-1:0]    CFG_STATIC,
  // Coprocessor register access
  input  wire crs_cp_req_t            CP_REQ,
  output logic [XLEN-1:0]             CP_RDATA,
  output logic                        CP_RVALID,
  // Translation entries
  input  wire logic                   TLB_WRITE,
  input  wire logic [$clog2(TLB_ENTRIES)-1:0] TLB_WR_IDX,
  input  wire logic [TLB_ENTRIES-1:0] TLB_RAW_MATCH,
  output logic [TLB_ENTRIES-1:0]      TLB_MATCH_EN,
  // Bus interface
  input  wire logic                   BUS_REQ,
  input  wire logic                   BUS_DONE,
  output logic                        BUS_PENDING,
  output logic                        BUS_ABORT,
  // First fetch
  output logic                        FETCH_VALID,
  output logic [XLEN-1:0]             FETCH_VA,
  output logic [XLEN-1:0]             FETCH_PA,
  // Timer
  input  wire logic                   TIMER_HIT,
  output logic                        TIMER_PEND,
  // General registers
  input  wire logic                   GPR_WE,
  input  wire logic [4:0]             GPR_WIDX,
  input  wire logic [XLEN-1:0]        GPR_WDATA,
  input  wire logic [4:0]             GPR_RIDX,
  output logic [XLEN-1:0]             GPR_RDATA,
  // Architectural flags
  output crs_arch_flags_t             ARCH_FLAGS
);

  localparam int IDX_W = (TLB_ENTRIES > 1) ? $clog2(TLB_ENTRIES) : 1;
  localparam logic [IDX_W-1:0] IDX_MAX = IDX_W'(TLB_ENTRIES - 1);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (TLB_ENTRIES < 2 || TLB_ENTRIES > 64) begin : g_bad_tlb
    $error("TLB_ENTRIES must lie between 2 and 64");
  end
  if (KSCR_MASK[1] || (DEBUG_IMPL && KSCR_MASK[0])) begin : g_bad_sel
    $error("KSCR_MASK populates a select reserved for debug use");
  end
  if (KSCR_MASK[7:4] != 4'h0 || KSCR_MASK[0]) begin : g_bad_mask
    $error("KSCR_MASK may only populate selects 2 and 3");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    crs_arch_flags_t            fl;
    logic [2:0]                 watch_en;
    logic [IDX_W-1:0]           random;
    logic [IDX_W-1:0]           wired;
    logic [2:0]                 k0;
    logic [2:0]                 ku;
    logic [2:0]                 k23;
    logic [STATIC_W-1:0]        cfg_static;
    logic [XLEN-1:0]            ctx;
    logic [1:0]                 pg_mask;
    logic                       loadstore_normal_access;
    logic                       ibep;
    logic                       dbep;
    logic                       fetch_exec_inhibit;
    logic                       single_step;
    logic [TLB_ENTRIES-1:0]     match_en;
    logic [XLEN-1:0]            compare;
    logic                       timer_pend;
    crs_biu_state_t             biu;
    logic                       pend;
    logic                       abort;
    logic                       fetch_pend;
    logic                       fetch_valid;
    logic [XLEN-1:0]            fetch_va;
    logic [XLEN-1:0]            fetch_pa;
    logic [XLEN-1:0]            rdata;
    logic                       rvalid;
    logic [XLEN-1:0]            gpr_rdata;
    logic [31:0][XLEN-1:0]      gpr;
  } crs_state_t;

  crs_state_t q;
  crs_state_t d;

  logic                   any_rst;
  logic                   cp_wr;
  logic                   cp_rd;
  logic [TLB_ENTRIES-1:0] live_match;
  logic                   multi_match;
  logic [XLEN-1:0]        rd_word;
  logic [XLEN-1:0]        status_word;
  logic [XLEN-1:0]        debug_word;
  logic [XLEN-1:0]        config_word;
  logic [2:0]             scr_wr;
  logic [2:0][XLEN-1:0]   scr_q;

  // Qualified strobes; writes are dropped while a reset is held
  assign any_rst = RST | SOFT_RST;
  assign cp_wr   = CE & ~any_rst & CP_REQ.wr;
  assign cp_rd   = CE & ~any_rst & CP_REQ.rd;

  // ----------------------------------------------------------------------
  // Scratch storage: debug-save and two kernel scratch words
  // ----------------------------------------------------------------------
  // Word 0 is the debug-save word; words 1 and 2 sit at selects 2 and 3
  always_comb begin
    scr_wr[0] = cp_wr && CP_REQ.regn == REG_SCRATCH && CP_REQ.sel == SEL_ZERO;
    scr_wr[1] = cp_wr && CP_REQ.regn == REG_SCRATCH && CP_REQ.sel == 3'h2
                && KSCR_MASK[2];
    scr_wr[2] = cp_wr && CP_REQ.regn == REG_SCRATCH && CP_REQ.sel == 3'h3
                && KSCR_MASK[3];
  end

  for (genvar i = 0; i < 3; i++) begin : g_scr
    crs_scratch_word #(
      .W (XLEN)
    ) u_word (
      .clk   (SYS_CLK),
      .wr_en (scr_wr[i]),
      .wdata (CP_REQ.wdata),
      .q     (scr_q[i])
    );
  end

  // ----------------------------------------------------------------------
  // Readback views
  // ----------------------------------------------------------------------
  // Assemble the packed register words from their fields
  always_comb begin
    status_word         = '0;
    status_word[ST_BEV] = q.fl.boot_vector_select;
    status_word[ST_TS]  = q.fl.ts;
    status_word[ST_SR]  = q.fl.sr;
    status_word[ST_NMI] = q.fl.nmi;
    status_word[ST_ERL] = q.fl.error_level;
    status_word[ST_RP]  = q.fl.rp;
    debug_word          = '0;
    debug_word[DB_DM]   = q.fl.dm;
    debug_word[DB_LOADSTORE_NORMAL_ACCESS] = q.loadstore_normal_access;
    debug_word[DB_IBEP] = q.ibep;
    debug_word[DB_DBEP] = q.dbep;
    debug_word[DB_FETCH_EXEC_INHIBIT] = q.fetch_exec_inhibit;
    debug_word[DB_SST]  = q.single_step;
    config_word         = '0;
    config_word[CF_K0 +: 3]         = q.k0;
    config_word[CF_STAT +: STATIC_W] = q.cfg_static;
    config_word[CF_KU +: 3]         = q.ku;
    config_word[CF_K23 +: 3]        = q.k23;
  end

  // Register read decode; unmapped numbers read as zero
  always_comb begin
    rd_word = '0;
    case (CP_REQ.regn)
      REG_RANDOM:  rd_word = XLEN'(q.random);
      REG_WIRED:   rd_word = XLEN'(q.wired);
      REG_CTXCFG:  rd_word = (CP_REQ.sel == SEL_ONE) ? q.ctx : '0;
      REG_PGRAIN:  rd_word = (CP_REQ.sel == SEL_ONE) ? XLEN'(q.pg_mask) : '0;
      REG_COMPARE: rd_word = q.compare;
      REG_STATUS:  rd_word = status_word;
      REG_WATCH:   rd_word = XLEN'(q.watch_en);
      REG_DEBUG:   rd_word = debug_word;
      REG_CONFIG: begin
        if (CP_REQ.sel == SEL_ZERO) begin
          rd_word = config_word;
        end else if (CP_REQ.sel == SEL_CONFIG_WORD_FOUR) begin
          rd_word[C4_MASK +: 8] = KSCR_MASK;
        end
      end
      REG_SCRATCH: begin
        case (CP_REQ.sel)
          3'h0:    rd_word = scr_q[0];
          3'h2:    rd_word = KSCR_MASK[2] ? scr_q[1] : '0;
          3'h3:    rd_word = KSCR_MASK[3] ? scr_q[2] : '0;
          default: rd_word = '0;
        endcase
      end
      default:     rd_word = '0;
    endcase
  end

  // Entries still carrying the hidden bit never match
  assign live_match  = TLB_RAW_MATCH & q.match_en;
  assign multi_match = (live_match & (live_match - 1'b1)) != '0;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Reset loading has priority over the clock enable
  always_comb begin
    d           = q;
    if (any_rst) begin
      d.fl.boot_vector_select      = 1'b1;
      d.fl.sr       = SOFT_RST & ~RST;
      d.fl.error_level      = 1'b1;
      d.fl.ts       = 1'b0;
      d.fl.nmi      = 1'b0;
      d.fl.rp       = 1'b0;
      d.watch_en    = 3'h0;
      d.random      = HAS_TLB ? IDX_MAX : '0;
      d.wired       = '0;
      d.cfg_static  = CFG_STATIC;
      d.k0          = CCA_UNCACHED;
      d.ku          = FIXED_MAP ? CCA_UNCACHED : q.ku;
      d.k23         = FIXED_MAP ? CCA_UNCACHED : q.k23;
      d.ctx         = CTX_RESET;
      d.pg_mask     = PG_MASK_RESET;
      d.fl.dm       = DEBUG_BOOT & DEBUG_IMPL;
      d.loadstore_normal_access        = 1'b0;
      d.ibep        = 1'b0;
      d.dbep        = 1'b0;
      d.fetch_exec_inhibit        = 1'b0;
      d.single_step         = 1'b0;
      d.match_en    = '0;
      d.biu         = BIU_IDLE;
      d.abort       = 1'b1;
      d.fetch_pend  = 1'b1;
      d.fetch_valid = 1'b0;
      d.rvalid      = 1'b0;
      // General registers keep their contents
    end else if (CE) begin
      d.abort  = 1'b0; // Abort drops on the first enabled edge after release
      d.rvalid = 1'b0;
      // Random walks down from the top to the wired limit and wraps
      d.random = (q.random <= q.wired) ? IDX_MAX : q.random - 1'b1;
      // Hidden bit clears when its entry is written
      if (TLB_WRITE) begin
        d.match_en[TLB_WR_IDX] = 1'b1;
      end
      // Two or more live matches shut translation down
      if (multi_match) begin
        d.fl.ts = 1'b1;
      end
      // Bus machine: one pending transaction at a time
      case (q.biu)
        BIU_IDLE: d.biu = BUS_REQ ? BIU_PEND : BIU_IDLE;
        BIU_PEND: d.biu = BUS_DONE ? BIU_IDLE : BIU_PEND;
        default:  d.biu = BIU_IDLE;
      endcase
      // First fetch after release, one cycle
      d.fetch_valid = q.fetch_pend;
      d.fetch_pend  = 1'b0;
      if (q.fetch_pend) begin
        d.fetch_va = q.fl.dm ? DEBUG_VA : BOOT_VA;
        d.fetch_pa = q.fl.dm ? (DEBUG_VA & SEG_PHYS_MASK) : BOOT_PA;
      end
      // Register writes
      if (cp_wr) begin
        case (CP_REQ.regn)
          REG_STATUS: begin
            d.fl.boot_vector_select = CP_REQ.wdata[ST_BEV];
            d.fl.ts  = CP_REQ.wdata[ST_TS] | multi_match;
            d.fl.sr  = CP_REQ.wdata[ST_SR];
            d.fl.nmi = CP_REQ.wdata[ST_NMI];
            d.fl.error_level = CP_REQ.wdata[ST_ERL];
            d.fl.rp  = CP_REQ.wdata[ST_RP];
          end
          REG_WIRED: begin
            d.wired  = CP_REQ.wdata[IDX_W-1:0];
            d.random = IDX_MAX;
          end
          REG_CONFIG: begin
            if (CP_REQ.sel == SEL_ZERO) begin
              d.k0 = CP_REQ.wdata[CF_K0 +: 3];
              if (FIXED_MAP) begin
                d.ku  = CP_REQ.wdata[CF_KU +: 3];
                d.k23 = CP_REQ.wdata[CF_K23 +: 3];
              end
            end
          end
          REG_CTXCFG:  d.ctx      = (CP_REQ.sel == SEL_ONE) ? CP_REQ.wdata : q.ctx;
          REG_PGRAIN:  d.pg_mask  = (CP_REQ.sel == SEL_ONE) ? CP_REQ.wdata[1:0] : q.pg_mask;
          REG_WATCH:   d.watch_en = CP_REQ.wdata[2:0];
          REG_COMPARE: d.compare  = CP_REQ.wdata;
          REG_DEBUG: begin
            d.loadstore_normal_access = CP_REQ.wdata[DB_LOADSTORE_NORMAL_ACCESS];
            d.single_step  = CP_REQ.wdata[DB_SST];
          end
          default: d.compare = q.compare;
        endcase
      end
      // Compare write clears the timer flag; a new hit in that cycle wins
      if (TIMER_HIT) begin
        d.timer_pend = 1'b1;
      end else if (cp_wr && CP_REQ.regn == REG_COMPARE) begin
        d.timer_pend = 1'b0;
      end
      // Register reads answer one cycle later
      if (cp_rd) begin
        d.rdata  = rd_word;
        d.rvalid = 1'b1;
      end
      // General registers; index zero is never stored and reads zero
      if (GPR_WE && GPR_WIDX != 5'h00) begin
        d.gpr[GPR_WIDX] = GPR_WDATA;
      end
      d.gpr_rdata = (GPR_RIDX == 5'h00) ? '0 : q.gpr[GPR_RIDX];
    end
    d.pend = (d.biu == BIU_PEND); // Flopped copy for the pending pin
  end

  // State register
  always_ff @(posedge SYS_CLK) begin
    q <= d;
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------------------------------------
  assign CP_RDATA     = q.rdata;
  assign CP_RVALID    = q.rvalid;
  assign TLB_MATCH_EN = q.match_en;
  assign BUS_PENDING  = q.pend;
  assign BUS_ABORT    = q.abort;
  assign FETCH_VALID  = q.fetch_valid;
  assign FETCH_VA     = q.fetch_va;
  assign FETCH_PA     = q.fetch_pa;
  assign TIMER_PEND   = q.timer_pend;
  assign GPR_RDATA    = q.gpr_rdata;
  assign ARCH_FLAGS   = q.fl;

endmodule : crs_core_reset

// >>> crs_core_reset_monitor.sv
// Checker for the core reset state block: reset loading, first fetch,
// hidden translation entries, bus abort, timer clear and register zero.
// Assumes it is bound to crs_core_reset and sees only that module's ports.
`timescale 1ns/1ps
module crs_core_reset_monitor
  import crs_pkg::*;
#(
  parameter int TLB_ENTRIES = 16
) (
  // Clock, enable and resets
  input wire logic                            SYS_CLK,
  input wire logic                            RST,
  input wire logic                            SOFT_RST,
  input wire logic                            CE,
  input wire logic                            DEBUG_BOOT,
  // Coprocessor and timer
  input wire crs_cp_req_t                     CP_REQ,
  input wire logic                            TIMER_HIT,
  input wire logic                            TIMER_PEND,
  // Translation entries
  input wire logic                            TLB_WRITE,
  input wire logic [$clog2(TLB_ENTRIES)-1:0]  TLB_WR_IDX,
  input wire logic [TLB_ENTRIES-1:0]          TLB_MATCH_EN,
  // Bus, fetch, registers and flags
  input wire logic                            BUS_PENDING,
  input wire logic                            BUS_ABORT,
  input wire logic                            FETCH_VALID,
  input wire logic [XLEN-1:0]                 FETCH_VA,
  input wire logic [XLEN-1:0]                 FETCH_PA,
  input wire logic [4:0]                      GPR_RIDX,
  input wire logic [XLEN-1:0]                 GPR_RDATA,
  input wire crs_arch_flags_t                 ARCH_FLAGS
);
  // Either reset in force
  logic rst_any;
  assign rst_any = RST | SOFT_RST;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (rst_any);

  // ----------
  // Reset loading, checked at the first edge after release
  // ----------
  boot_flags_a: assert property (
    $past(rst_any) |-> ARCH_FLAGS.boot_vector_select && ARCH_FLAGS.error_level && !ARCH_FLAGS.ts
      && !ARCH_FLAGS.nmi && !ARCH_FLAGS.rp)
    else $error("status flags wrong after reset");
  sr_load_a: assert property ($past(rst_any) |-> ARCH_FLAGS.sr == !$past(RST))
    else $error("soft reset flag wrong");
  dm_load_a: assert property ($past(rst_any) |-> ARCH_FLAGS.dm == $past(DEBUG_BOOT))
    else $error("debug mode flag wrong after reset");
  hidden_clear_a: assert property ($past(rst_any) |-> TLB_MATCH_EN == '0)
    else $error("entry may match after reset");
  bus_abort_a: assert property ($past(rst_any) |-> BUS_ABORT && !BUS_PENDING)
    else $error("bus not aborted by reset");

  // ----------
  // First fetch, entries, timer and register zero
  // ----------
  fetch_first_a: assert property (
    $past(rst_any) && CE |=> FETCH_VALID && !BUS_ABORT)
    else $error("first fetch missing after release");
  boot_addr_a: assert property (
    FETCH_VALID && !ARCH_FLAGS.dm |-> FETCH_VA == BOOT_VA && FETCH_PA == BOOT_PA)
    else $error("boot fetch address wrong");
  debug_addr_a: assert property (
    FETCH_VALID && ARCH_FLAGS.dm |-> FETCH_PA == (FETCH_VA & SEG_PHYS_MASK))
    else $error("debug fetch physical address wrong");
  entry_enable_a: assert property (
    CE && TLB_WRITE |=> TLB_MATCH_EN[$past(TLB_WR_IDX)])
    else $error("written entry still hidden");
  zero_reg_a: assert property (CE && GPR_RIDX == 5'h00 |=> GPR_RDATA == '0)
    else $error("register zero not zero");
  timer_clear_a: assert property (
    CE && CP_REQ.wr && CP_REQ.regn == REG_COMPARE && CP_REQ.sel == SEL_ZERO
      && !TIMER_HIT |=> !TIMER_PEND)
    else $error("compare write left timer pending");

  // Main scenarios
  cover property ($past(SOFT_RST) && !rst_any);
  cover property (FETCH_VALID && ARCH_FLAGS.dm);
  cover property (TIMER_PEND ##1 !TIMER_PEND);
endmodule : crs_core_reset_monitor

bind crs_core_reset crs_core_reset_monitor #(.TLB_ENTRIES(TLB_ENTRIES)) u_crs_core_reset_monitor (
  .SYS_CLK(SYS_CLK), .RST(RST), .SOFT_RST(SOFT_RST), .CE(CE), .DEBUG_BOOT(DEBUG_BOOT),
  .CP_REQ(CP_REQ), .TIMER_HIT(TIMER_HIT), .TIMER_PEND(TIMER_PEND), .TLB_WRITE(TLB_WRITE),
  .TLB_WR_IDX(TLB_WR_IDX), .TLB_MATCH_EN(TLB_MATCH_EN), .BUS_PENDING(BUS_PENDING),
  .BUS_ABORT(BUS_ABORT), .FETCH_VALID(FETCH_VALID), .FETCH_VA(FETCH_VA), .FETCH_PA(FETCH_PA),
  .GPR_RIDX(GPR_RIDX), .GPR_RDATA(GPR_RDATA), .ARCH_FLAGS(ARCH_FLAGS));

// >>> tb_crs_core_reset.sv
// Self-checking bench for the core reset state block.
// Assumes a 200 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module tb_crs_core_reset
  import crs_pkg::*;
;
  localparam logic [31:0] DVA = 32'hff200200; // Arbitrary debug vector
  localparam logic [31:0] STM = 32'h08780004; // Status bits loaded by reset
  localparam logic [31:0] DBM = 32'h51200120; // Debug bits loaded by reset
  logic        SYS_CLK, RST, SOFT_RST, CE, DEBUG_BOOT, TLB_WRITE, BUS_REQ, BUS_DONE;
  logic        TIMER_HIT, GPR_WE, CP_RVALID, BUS_PENDING, BUS_ABORT, FETCH_VALID, TIMER_PEND;
  logic [15:0] CFG_STATIC, TLB_RAW_MATCH, TLB_MATCH_EN;
  logic [3:0]  TLB_WR_IDX, ix;
  logic [4:0]  GPR_WIDX, GPR_RIDX;
  logic [31:0] CP_RDATA, FETCH_VA, FETCH_PA, GPR_WDATA, GPR_RDATA, seed, v;
  crs_cp_req_t     CP_REQ;
  crs_arch_flags_t ARCH_FLAGS;
  int          miscompares, total_checks, cyc;

  crs_core_reset #(.DEBUG_VA(DVA)) u_crs_core_reset (
    .SYS_CLK(SYS_CLK), .RST(RST), .SOFT_RST(SOFT_RST), .CE(CE), .DEBUG_BOOT(DEBUG_BOOT),
    .CFG_STATIC(CFG_STATIC), .CP_REQ(CP_REQ), .CP_RDATA(CP_RDATA), .CP_RVALID(CP_RVALID),
    .TLB_WRITE(TLB_WRITE), .TLB_WR_IDX(TLB_WR_IDX), .TLB_RAW_MATCH(TLB_RAW_MATCH),
    .TLB_MATCH_EN(TLB_MATCH_EN), .BUS_REQ(BUS_REQ), .BUS_DONE(BUS_DONE),
    .BUS_PENDING(BUS_PENDING), .BUS_ABORT(BUS_ABORT), .FETCH_VALID(FETCH_VALID),
    .FETCH_VA(FETCH_VA), .FETCH_PA(FETCH_PA), .TIMER_HIT(TIMER_HIT), .TIMER_PEND(TIMER_PEND),
    .GPR_WE(GPR_WE), .GPR_WIDX(GPR_WIDX), .GPR_WDATA(GPR_WDATA), .GPR_RIDX(GPR_RIDX),
    .GPR_RDATA(GPR_RDATA), .ARCH_FLAGS(ARCH_FLAGS));

  // ----------
  // Helpers
  // ----------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs
  function automatic logic [31:0] st_exp(input logic sr);
    return (32'h1 << ST_BEV) | (32'h1 << ST_ERL) | ({31'h0, sr} << ST_SR);
  endfunction : st_exp
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cp_wr(input logic [4:0] r, input logic [2:0] s, input logic [31:0] d);
    @(negedge SYS_CLK);
    CP_REQ = '{1'b0, 1'b1, r, s, d};
    @(negedge SYS_CLK);
    CP_REQ = '0;
  endtask : cp_wr
  // Read one word and compare it under a mask
  task automatic rc(input string n, input logic [4:0] r, input logic [2:0] s,
                    input logic [31:0] m, input logic [31:0] e);
    @(negedge SYS_CLK);
    CP_REQ = '{1'b1, 1'b0, r, s, 32'h0};
    @(negedge SYS_CLK);
    CP_REQ = '0;
    v = CP_RDATA;
    chk("rvalid", CP_RVALID, 32'h1);
    chk(n, v & m, e);
  endtask : rc
  // Hold a reset two cycles, then check flags and the first fetch
  task automatic do_rst(input logic cold, input logic dbg, input logic [15:0] cfg);
    @(negedge SYS_CLK);
    RST = cold;
    SOFT_RST = !cold;
    DEBUG_BOOT = dbg;
    CFG_STATIC = cfg;
    repeat (2) @(negedge SYS_CLK);
    chk("abort", BUS_ABORT, 32'h1);
    RST = 1'b0;
    SOFT_RST = 1'b0;
    @(negedge SYS_CLK);
    chk("abort_end", BUS_ABORT, 32'h0);
    chk("flags", ARCH_FLAGS, {1'b1, 1'b0, !cold, 1'b0, 1'b1, 1'b0, dbg});
    chk("fetch", FETCH_VALID, 32'h1);
    chk("fetch_va", FETCH_VA, dbg ? DVA : BOOT_VA);
    chk("fetch_pa", FETCH_PA, dbg ? (DVA & SEG_PHYS_MASK) : BOOT_PA);
  endtask : do_rst
  task automatic gp(input logic [4:0] i, input logic [31:0] d, input logic [31:0] e);
    @(negedge SYS_CLK);
    GPR_WE = 1'b1;
    GPR_WIDX = i;
    GPR_WDATA = d;
    @(negedge SYS_CLK);
    GPR_WE = 1'b0;
    GPR_RIDX = i;
    @(negedge SYS_CLK);
    chk("gpr", GPR_RDATA, e);
  endtask : gp
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // Clock and hang guard
  initial begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      wrap_up();
    end
  end

  // ----------
  // Main sequence
  // ----------
  initial begin
    {RST, SOFT_RST, DEBUG_BOOT, TLB_WRITE, BUS_REQ, BUS_DONE, TIMER_HIT, GPR_WE} = 8'h00;
    CE = 1'b1;
    CFG_STATIC = 16'h0000;
    CP_REQ = '0;
    TLB_WR_IDX = 4'h0;
    TLB_RAW_MATCH = 16'hffff;
    {GPR_WIDX, GPR_RIDX, GPR_WDATA} = '0;
    seed = 32'h0d2f;
    seed = xs(seed);
    do_rst(1'b1, 1'b0, seed[15:0]);
    rc("random", REG_RANDOM, SEL_ZERO, 32'hfffffffc, 32'h0000000c);
    rc("wired", REG_WIRED, SEL_ZERO, 32'hffffffff, 32'h0);
    rc("status", REG_STATUS, SEL_ZERO, STM, st_exp(1'b0));
    rc("config", REG_CONFIG, SEL_ZERO, 32'h0007ffff, {seed[15:0], CCA_UNCACHED});
    rc("presence", REG_CONFIG, SEL_CONFIG_WORD_FOUR, 32'h00ff0000, 32'h000c0000);
    rc("context", REG_CTXCFG, SEL_ONE, 32'hffffffff, 32'h007ffff0);
    rc("pgmask", REG_PGRAIN, SEL_ONE, 32'h3, 32'h3);
    rc("watch", REG_WATCH, SEL_ZERO, 32'h7, 32'h0);
    rc("debug", REG_DEBUG, SEL_ZERO, DBM, 32'h0);
    $display("test cold_reset done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      cp_wr(REG_SCRATCH, i[2:0], seed);
      rc("scratch", REG_SCRATCH, i[2:0], '1, (i == 1) ? 32'h0 : seed);
    end
    CE = 1'b0;
    cp_wr(REG_SCRATCH, 3'h3, ~seed);
    CE = 1'b1;
    rc("ce_hold", REG_SCRATCH, 3'h3, '1, seed);
    rc("unmapped", 5'h03, SEL_ZERO, '1, 32'h0);
    $display("test scratch done");
    ix = seed[3:0];
    for (int i = 0; i < 2; i++) begin
      @(negedge SYS_CLK);
      TLB_WRITE = 1'b1;
      TLB_WR_IDX = ix ^ i[3:0];
      @(negedge SYS_CLK);
      TLB_WRITE = 1'b0;
    end
    chk("match_en", TLB_MATCH_EN, (16'h1 << ix) | (16'h1 << (ix ^ 4'h1)));
    rc("ts_set", REG_STATUS, SEL_ZERO, 32'h1 << ST_TS, 32'h1 << ST_TS);
    $display("test entries done");
    @(negedge SYS_CLK);
    BUS_REQ = 1'b1;
    @(negedge SYS_CLK);
    BUS_REQ = 1'b0;
    chk("pending", BUS_PENDING, 32'h1);
    seed = xs(seed);
    do_rst(1'b0, 1'b1, seed[15:0]);
    chk("pending_rst", BUS_PENDING, 32'h0);
    chk("match_rst", TLB_MATCH_EN, 32'h0);
    rc("status_soft", REG_STATUS, SEL_ZERO, STM, st_exp(1'b1));
    rc("debug_dm", REG_DEBUG, SEL_ZERO, DBM, 32'h1 << DB_DM);
    $display("test soft_reset done");
    @(negedge SYS_CLK);
    TIMER_HIT = 1'b1;
    @(negedge SYS_CLK);
    TIMER_HIT = 1'b0;
    chk("timer_pend", TIMER_PEND, 32'h1);
    cp_wr(REG_COMPARE, SEL_ZERO, seed);
    chk("timer_clear", TIMER_PEND, 32'h0);
    gp(5'h00, seed, 32'h0);
    gp(5'h05, ~seed, ~seed);
    cp_wr(REG_STATUS, SEL_ZERO, STM);
    rc("status_wr", REG_STATUS, SEL_ZERO, STM, STM);
    $display("test timer_gpr done");
    do_rst(1'b1, 1'b0, ~seed[15:0]);
    rc("config2", REG_CONFIG, SEL_ZERO, 32'h0007ffff, {~seed[15:0], CCA_UNCACHED});
    $display("test config_reload done");
    wrap_up();
  end
endmodule : tb_crs_core_reset
